// *** rtl/fsm_host.sv ***
// host controller driving flash status reads and command sequences over AHB-Lite
//
// Contract
// - strobes high after status read access
// - mask reserved bits 15:8
// - ignore bits 6:1 while busy
// - poll status until ready after suspend
// - mask continuity bit 0
// - bad sequence needs reset command
// - entry before mode commands, exit after
// - each password byte two-cycle program
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module fsm_host
   import fsm_pkg::*;
(
   input  wire logic        clk_in,        // 25 MHz clock
   input  wire logic        resetn_in,     // sync reset, active low
   input  wire logic        hsel_in,       // ahb select
   input  wire logic [31:0] haddr_in,      // ahb address
   input  wire logic [1:0]  htrans_in,     // ahb transfer type
   input  wire logic        hwrite_in,     // ahb write
   input  wire logic [2:0]  hsize_in,      // ahb size
   input  wire logic [31:0] hwdata_in,     // ahb write data
   input  wire logic        hready_in,     // ahb bus ready
   output logic [31:0]      hrdata_out,    // ahb read data
   output logic             hreadyout_out, // ahb slave ready
   output logic             hresp_out,     // ahb response, always okay
   output logic [11:0]      f_addr_out,    // flash address
   output logic [15:0]      f_dq_out,      // flash data out
   output logic             f_dq_oe_out,   // flash data drive enable
   input  wire logic [15:0] f_dq_in,       // flash data in
   output logic             f_cen_out,     // flash chip enable, low
   output logic             f_oen_out,     // flash output enable, low
   output logic             f_wen_out      // flash write enable, low
);
   import fsm_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_CYC, S_NEXT, S_DONE} fsm_st_e;
   typedef struct packed {
      fsm_st_e     st;
      logic [2:0]  op;
      logic [4:0]  step;
      logic [3:0]  pw_idx;
      logic [11:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [15:0] fstat;
      logic        busy;
      logic        fail;
      logic        seqerr;
      logic        unprot;
      logic        ap_valid;
      logic        ap_wr;
      logic [7:0]  ap_addr;
   } fsm_host_s;
   fsm_host_s s_r, s_nxt;

   fsm_cyc_if cyc ();
   logic        c_req;
   logic        c_wr;
   logic [11:0] c_addr;
   logic [15:0] c_wd;
   logic        last;

   assign cyc.req   = c_req;
   assign cyc.wr    = c_wr;
   assign cyc.addr  = c_addr;
   assign cyc.wdata = c_wd;

   fsm_cycle u_cyc (
      .clk_in      (clk_in),
      .resetn_in   (resetn_in),
      .cyc         (cyc),
      .f_addr_out  (f_addr_out),
      .f_dq_out    (f_dq_out),
      .f_dq_oe_out (f_dq_oe_out),
      .f_dq_in     (f_dq_in),
      .f_cen_out   (f_cen_out),
      .f_oen_out   (f_oen_out),
      .f_wen_out   (f_wen_out)
   );

   // bus cycle per step of the selected sequence
   always_comb begin
      c_req  = (s_r.st == S_CYC);
      c_wr   = 1'b1;
      c_addr = ADDR_ANY;
      c_wd   = 16'h0000;
      last   = 1'b0;
      case (fsm_op_e'(s_r.op))
         // write command then exactly one read of the overlay
         FSM_OP_STATUS, FSM_OP_POLL: begin
            c_wd = {8'h00, CMD_STATUS};
            if (s_r.step == 5'd1) begin
               c_wr = 1'b0;
               last = 1'b1;
            end
         end
         FSM_OP_CLEAR: begin c_wd = {8'h00, CMD_CLEAR}; last = 1'b1; end
         FSM_OP_RESET: begin c_wd = {8'h00, CMD_RESET}; last = 1'b1; end
         FSM_OP_WRITE: begin c_addr = s_r.addr; c_wd = s_r.wdata; last = 1'b1; end
         FSM_OP_READ:  begin c_addr = s_r.addr; c_wr = 1'b0; last = 1'b1; end
         // entry, two-cycle program per byte or one protection read, exit
         FSM_OP_PW_PROG, FSM_OP_PROT_RD: begin
            case (s_r.step)
               5'd0: begin c_addr = ADDR_UNLK1; c_wd = {8'h00, CMD_UNLK1}; end
               5'd1: begin c_addr = ADDR_UNLK2; c_wd = {8'h00, CMD_UNLK2}; end
               5'd2: begin
                  c_addr = ADDR_UNLK1;
                  c_wd   = {8'h00, (s_r.op == 3'(FSM_OP_PW_PROG)) ? CMD_ENTRY_PW
                                                                  : CMD_ENTRY_DYB};
               end
               5'd3: begin
                  if (s_r.op == 3'(FSM_OP_PW_PROG)) begin
                     c_wd = {8'h00, CMD_PROG};
                  end else begin
                     c_addr = s_r.addr;
                     c_wr   = 1'b0;
                  end
               end
               5'd4: begin
                  if (s_r.op == 3'(FSM_OP_PW_PROG)) begin
                     c_addr = {8'h00, s_r.pw_idx};
                     c_wd   = s_r.wdata;
                  end else begin
                     c_wd = {8'h00, CMD_EXIT1};
                  end
               end
               5'd5: begin
                  if (s_r.op == 3'(FSM_OP_PW_PROG)) c_wd = {8'h00, CMD_EXIT1};
                  else                              c_wd = {8'h00, CMD_EXIT2};
                  last = (s_r.op != 3'(FSM_OP_PW_PROG));
               end
               default: begin c_wd = {8'h00, CMD_EXIT2}; last = 1'b1; end
            endcase
         end
         default: last = 1'b1;
      endcase
   end

   // ahb slave and sequencer state; answers with zero wait states
   always_comb begin
      logic        take;
      logic [15:0] stat;
      take  = 1'b0;
      stat  = 16'h0000;
      s_nxt = s_r;
      s_nxt.ap_valid = hsel_in && hready_in && htrans_in[1];
      if (s_nxt.ap_valid) begin
         s_nxt.ap_wr   = hwrite_in;
         s_nxt.ap_addr = haddr_in[7:0];
      end
      if (s_r.ap_valid && s_r.ap_wr) begin
         case (s_r.ap_addr)
            OFF_ADDR:  s_nxt.addr  = hwdata_in[11:0];
            OFF_WDATA: s_nxt.wdata = hwdata_in[15:0];
            OFF_CTRL:  take = hwdata_in[CTRL_GO_BIT] && (s_r.st == S_IDLE);
            default: ;
         endcase
      end
      if (take) begin
         s_nxt.op     = hwdata_in[CTRL_OP_LO +: CTRL_OP_W];
         s_nxt.st     = S_CYC;
         s_nxt.step   = 5'd0;
         s_nxt.pw_idx = 4'h0;
         s_nxt.busy   = 1'b1;
         s_nxt.fail   = 1'b0;
         s_nxt.seqerr = 1'b0;
      end
      case (s_r.st)
         S_IDLE: ;
         S_CYC: if (cyc.done) begin
            if (!c_wr) s_nxt.rdata = cyc.rdata;
            s_nxt.st = last ? S_DONE : S_NEXT;
         end
         S_NEXT: begin
            s_nxt.st   = S_CYC;
            s_nxt.step = s_r.step + 5'd1;
            // repeat program pair for all eight bytes
            if (s_r.op == 3'(FSM_OP_PW_PROG) && s_r.step == 5'd4
                && s_r.pw_idx != PW_BYTES - 4'h1) begin
               s_nxt.step   = 5'd3;
               s_nxt.pw_idx = s_r.pw_idx + 4'h1;
            end
         end
         S_DONE: begin
            s_nxt.st   = S_IDLE;
            s_nxt.busy = 1'b0;
            stat = s_r.rdata & FS_VALID_MASK;
            if (s_r.op == 3'(FSM_OP_STATUS) || s_r.op == 3'(FSM_OP_POLL)) begin
               s_nxt.fstat = stat;
               // results only trusted once ready
               if (stat[FS_READY]) begin
                  s_nxt.fail = |(stat & FS_FAIL_MASK);
               end else if (s_r.op == 3'(FSM_OP_POLL)) begin
                  s_nxt.st   = S_CYC;                             // keep polling
                  s_nxt.step = 5'd0;
                  s_nxt.busy = 1'b1;
               end
            end
            if (s_r.op == 3'(FSM_OP_PROT_RD)) begin
               s_nxt.unprot = s_r.rdata[0];
            end
         end
         default: s_nxt.st = S_IDLE;
      endcase
      // go while a sequence runs is refused and flagged, no stray flash cycles
      if (s_r.ap_valid && s_r.ap_wr && s_r.ap_addr == OFF_CTRL
          && hwdata_in[CTRL_GO_BIT] && s_r.st != S_IDLE) begin
         s_nxt.seqerr = 1'b1;
      end
   end

   // reset leaves every view and flag cleared
   always_ff @(posedge clk_in) begin
      if (!resetn_in) s_r <= '0;
      else            s_r <= s_nxt;
   end

   // read mux; flash status view keeps suspend bits
   always_comb begin
      hrdata_out = 32'h0000_0000;
      case (s_r.ap_addr)
         OFF_ADDR:   hrdata_out = {20'h00000, s_r.addr};
         OFF_WDATA:  hrdata_out = {16'h0000, s_r.wdata};
         OFF_CTRL:   hrdata_out = {29'h0000000, s_r.op};
         OFF_STATUS: hrdata_out = {28'h0000000, s_r.unprot, s_r.seqerr, s_r.fail, s_r.busy};
         OFF_RDATA:  hrdata_out = {16'h0000, s_r.rdata};
         OFF_FSTAT:  hrdata_out = {16'h0000, s_r.fstat};
         default:    hrdata_out = 32'h0000_0000;
      endcase
   end

   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;
endmodule : fsm_host
`default_nettype wire

// *** pkg/fsm_pkg.sv ***
// package for the flash status host controller: register map, commands, timing
`default_nettype none
package fsm_pkg;
   // software-visible registers of the controller (byte addresses)
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_ADDR     = 8'h04;
   localparam logic [7:0]  OFF_WDATA    = 8'h08;
   localparam logic [7:0]  OFF_STATUS   = 8'h0C;
   localparam logic [7:0]  OFF_RDATA    = 8'h10;
   localparam logic [7:0]  OFF_FSTAT    = 8'h14;
   // ctrl register fields
   localparam int          CTRL_OP_LO   = 0;
   localparam int          CTRL_OP_W    = 3;
   localparam int          CTRL_GO_BIT  = 31;
   // status register fields of the controller
   localparam int          ST_BUSY_BIT  = 0;
   localparam int          ST_FAIL_BIT  = 1;
   localparam int          ST_SEQERR_BIT = 2;
   localparam int          ST_UNPROT_BIT = 3;
   // flash status register fields
   localparam int          FS_READY     = 7;
   localparam int          FS_ERS_SUSP  = 6;
   localparam int          FS_ERS_FAIL  = 5;
   localparam int          FS_PRG_FAIL  = 4;
   localparam int          FS_BUF_ABORT = 3;
   localparam int          FS_PRG_SUSP  = 2;
   localparam int          FS_LOCKED    = 1;
   localparam int          FS_CONT      = 0;
   localparam logic [15:0] FS_VALID_MASK = 16'h00FE;
   localparam logic [15:0] FS_FAIL_MASK  = 16'h003A;
   // flash command codes and addresses
   localparam logic [7:0]  CMD_STATUS   = 8'h70;
   localparam logic [7:0]  CMD_CLEAR    = 8'h71;
   localparam logic [7:0]  CMD_RESET    = 8'hF0;
   localparam logic [7:0]  CMD_PROG     = 8'hA0;
   localparam logic [7:0]  CMD_EXIT1    = 8'h90;
   localparam logic [7:0]  CMD_EXIT2    = 8'h00;
   localparam logic [7:0]  CMD_UNLK1    = 8'hAA;
   localparam logic [7:0]  CMD_UNLK2    = 8'h55;
   localparam logic [7:0]  CMD_ENTRY_PW = 8'h60;
   localparam logic [7:0]  CMD_ENTRY_DYB = 8'hE0;
   localparam logic [11:0] ADDR_UNLK1   = 12'hAAA;
   localparam logic [11:0] ADDR_UNLK2   = 12'h555;
   localparam logic [11:0] ADDR_ANY     = 12'h000;
   localparam logic [3:0]  PW_BYTES     = 4'h8;
   // operations the controller performs
   typedef enum logic [2:0] {
      FSM_OP_STATUS, FSM_OP_CLEAR, FSM_OP_RESET, FSM_OP_PW_PROG,
      FSM_OP_PROT_RD, FSM_OP_WRITE, FSM_OP_READ, FSM_OP_POLL
   } fsm_op_e;
   // bus timing: phases in 40 ns cycles
   localparam int          CLK_NS       = 40;
   localparam int          T_STROBE_NS  = 70;
   localparam int          T_PH_NS      = 20;
   localparam logic [3:0]  STROBE_CYC   = 4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  PH_CYC       = 4'((T_PH_NS + CLK_NS - 1) / CLK_NS);
endpackage : fsm_pkg
`default_nettype wire

// *** pkg/fsm_cyc_if.sv ***
// interface between sequencer and flash bus-cycle engine
`timescale 1ns/1ps
`default_nettype none
interface fsm_cyc_if;
   logic        req;
   logic        wr;
   logic [11:0] addr;
   logic [15:0] wdata;
   logic        done;
   logic [15:0] rdata;
   modport seq (output req, wr, addr, wdata, input done, rdata);
   modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface : fsm_cyc_if
`default_nettype wire

// *** rtl/fsm_cycle.sv ***
// one asynchronous flash read or write cycle with strobe and pulse-high time
`timescale 1ns/1ps
`default_nettype none
module fsm_cycle
   import fsm_pkg::*;
(
   input  wire logic  clk_in,        // 25 MHz clock
   input  wire logic  resetn_in,     // sync reset, active low
   fsm_cyc_if.eng     cyc,           // cycle requests
   output logic [11:0] f_addr_out,   // flash address
   output logic [15:0] f_dq_out,     // flash data out
   output logic        f_dq_oe_out,  // dq driven by us
   input  wire logic [15:0] f_dq_in, // flash data in
   output logic        f_cen_out,    // chip enable, active low
   output logic        f_oen_out,    // output enable, active low
   output logic        f_wen_out     // write enable, active low
);
   import fsm_pkg::*;

   typedef enum logic [1:0] {C_IDLE, C_STROBE, C_HIGH} fsm_cst_e;
   typedef struct packed {
      fsm_cst_e    st;
      logic [3:0]  cnt;
      logic        wr;
      logic [11:0] addr;
      logic [15:0] wd;
      logic [15:0] rd;
      logic        done;
   } fsm_cyc_s;
   fsm_cyc_s s_r, s_nxt;

   // cycle sequencing; strobe then forced high time
   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      case (s_r.st)
         C_IDLE: if (cyc.req && !s_r.done) begin
            s_nxt.st   = C_STROBE;
            s_nxt.cnt  = STROBE_CYC;
            s_nxt.wr   = cyc.wr;
            s_nxt.addr = cyc.addr;
            s_nxt.wd   = cyc.wdata;
         end
         C_STROBE: if (s_r.cnt == 4'h1) begin
            s_nxt.st  = C_HIGH;
            s_nxt.cnt = PH_CYC;
            s_nxt.rd  = f_dq_in;          // sampled at end of strobe
         end else begin
            s_nxt.cnt = s_r.cnt - 4'h1;
         end
         // strobes held high so the overlay read ends cleanly
         C_HIGH: if (s_r.cnt == 4'h1) begin
            s_nxt.st   = C_IDLE;
            s_nxt.done = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt - 4'h1;
         end
         default: s_nxt.st = C_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) s_r <= '0;
      else            s_r <= s_nxt;
   end

   // pin drive from state flops
   assign cyc.done    = s_r.done;
   assign cyc.rdata   = s_r.rd;
   assign f_addr_out  = s_r.addr;
   assign f_dq_out    = s_r.wd;
   assign f_dq_oe_out = (s_r.st != C_IDLE) && s_r.wr;
   assign f_cen_out   = (s_r.st != C_STROBE);
   assign f_oen_out   = !((s_r.st == C_STROBE) && !s_r.wr);
   assign f_wen_out   = !((s_r.st == C_STROBE) && s_r.wr);
endmodule : fsm_cycle
`default_nettype wire

// *** bench/fsm_host_chk.sv ***
// protocol checker on the controller's bus and flash pins
`timescale 1ns/1ps
`default_nettype none
module fsm_host_chk (
   input wire logic        clk_in,        // clock
   input wire logic        resetn_in,     // sync reset, low
   input wire logic        hreadyout_out, // ahb ready
   input wire logic        hresp_out,     // ahb response
   input wire logic [11:0] f_addr_out,    // flash address
   input wire logic [15:0] f_dq_out,      // flash write data
   input wire logic        f_dq_oe_out,   // dq drive enable
   input wire logic        f_cen_out,     // chip enable, low
   input wire logic        f_oen_out,     // output enable, low
   input wire logic        f_wen_out      // write enable, low
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // a strobe is two low cycles, then high so the device sees the pulse-high time
   sequence s_rd_pulse; !f_oen_out ##1 f_oen_out; endsequence
   sequence s_wr_pulse; !f_wen_out ##1 f_wen_out; endsequence
   sequence s_status_cmd; $rose(f_wen_out) && f_dq_out == 16'h0070; endsequence
   property p_rd_pulse; $fell(f_oen_out) |=> s_rd_pulse; endproperty
   property p_wr_pulse; $fell(f_wen_out) |=> s_wr_pulse; endproperty
   property p_status_read; s_status_cmd |-> ##[1:6] $fell(f_oen_out); endproperty
   property p_no_both; !(!f_oen_out && !f_wen_out); endproperty
   property p_strobe_cen; (!f_oen_out || !f_wen_out) |-> !f_cen_out; endproperty
   property p_wr_drive; !f_wen_out |-> f_dq_oe_out; endproperty
   property p_rd_release; !f_oen_out |-> !f_dq_oe_out; endproperty
   property p_wr_hold;
      !f_wen_out && !$past(f_wen_out) |-> $stable(f_addr_out) && $stable(f_dq_out);
   endproperty
   property p_bus_ok; hreadyout_out && !hresp_out; endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe not two cycles low then high");
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe not two cycles low then high");
   a_status_read: assert property (p_status_read)
      else $error("status command not followed by a read");
   a_no_both: assert property (p_no_both)
      else $error("read and write strobes low together");
   a_strobe_cen: assert property (p_strobe_cen)
      else $error("strobe low without chip enable");
   a_wr_drive: assert property (p_wr_drive)
      else $error("write strobe without data drive");
   a_rd_release: assert property (p_rd_release)
      else $error("data driven during a read");
   a_wr_hold: assert property (p_wr_hold)
      else $error("address or data moved during write strobe");
   a_bus_ok: assert property (p_bus_ok)
      else $error("bus not ready or not okay");
endmodule // fsm_host_chk
bind fsm_host fsm_host_chk chk_u (.clk_in(clk_in), .resetn_in(resetn_in),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .f_addr_out(f_addr_out),
   .f_dq_out(f_dq_out), .f_dq_oe_out(f_dq_oe_out), .f_cen_out(f_cen_out),
   .f_oen_out(f_oen_out), .f_wen_out(f_wen_out));
`default_nettype wire

// *** bench/fsm_flash_model.sv ***
// behavioural flash: status overlay, clear, protection read and password set
`timescale 1ns/1ps
`default_nettype none
module fsm_flash_model (
   input  wire logic [11:0] addr_in, // flash address
   input  wire logic [15:0] dq_in,   // wire level of dq
   input  wire logic        cen_in,  // chip enable, low
   input  wire logic        oen_in,  // output enable, low
   input  wire logic        wen_in,  // write enable, low
   output logic      [15:0] dq_out   // device drive of dq
);
   logic [7:0]  sr = 8'h80;   // ready set, rest clear after reset
   logic [3:0]  busy_cnt = 0; // overlay reads left before ready
   logic        ovl = 0;      // next read returns status
   logic [1:0]  ulk = 0;      // unlock or exit cycles seen
   logic [7:0]  mode = 0;     // command set entered, 0 is array
   logic        pend = 0;     // program command seen in password set
   logic        unprot = 0;   // protection state of the addressed sector
   logic [15:0] pw [8];       // password bytes
   logic [15:0] rnd = 16'h5A3C;
   logic [15:0] last = 0;
   logic [15:0] rdv;
   // read value; reserved byte changes on every read, released bus never stale
   always @* begin
      if (ovl) rdv = {rnd[15:8], busy_cnt == 0, sr[6:0]};
      else if (mode == 8'hE0) rdv = {rnd[15:1], unprot};
      else rdv = {4'hA, addr_in};
      dq_out = (!cen_in && !oen_in) ? rdv : ~last;
   end
   // end of a read closes the overlay
   always @(posedge oen_in) begin
      last = rdv;
      rnd = {rnd[14:0], rnd[15] ^ rnd[13]};
      if (ovl && busy_cnt != 0) busy_cnt--;
      ovl = 0;
   end
   // command decoding on the rising edge of write enable
   always @(posedge wen_in) begin
      if (pend) begin
         pw[addr_in[2:0]] = dq_in;
         pend = 0;
      end else if (dq_in == 16'h0070) ovl = 1;
      else if (dq_in == 16'h0071 || dq_in == 16'h00F0) begin
         sr &= 8'hC4; // state bits kept
         mode = 0;
      end else if (ulk == 0 && dq_in == 16'h00AA) ulk = 1;
      else if (ulk == 1 && dq_in == 16'h0055) ulk = 2;
      else if (ulk == 2) begin
         mode = dq_in[7:0];
         ulk = 0;
      end else if (dq_in == 16'h0090) ulk = 3;
      else if (ulk == 3) begin
         mode = 0;
         ulk = 0;
      end else if (mode == 8'h60 && dq_in == 16'h00A0) pend = 1;
   end
endmodule // fsm_flash_model
`default_nettype wire

// *** bench/fsm_host_test.sv ***
// self-checking bench for the flash status host controller
`timescale 1ns/1ps
`default_nettype none
module fsm_host_test;
   import fsm_pkg::*;
   logic        clk_in = 0, resetn_in = 0, hwrite = 0, up = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r, seed = 32'h98B2;
   logic [31:0] hrdata_q;
   logic        hready, hresp, oe, cen, oen, wen;
   logic [11:0] fa;
   logic [15:0] fdo, mdq, fdi, d;
   logic [7:0]  s;
   int          miscompares = 0, checked = 0;
   // device drives dq unless the controller does
   assign fdi = oe ? fdo : mdq;
   always #20 clk_in = ~clk_in;
   // read data as it stood at the edge, free of the update race
   always @(posedge clk_in) hrdata_q <= hrdata;
   fsm_host dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(1'b1),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .f_addr_out(fa), .f_dq_out(fdo),
      .f_dq_oe_out(oe), .f_dq_in(fdi), .f_cen_out(cen), .f_oen_out(oen),
      .f_wen_out(wen));
   fsm_flash_model flash_u (.addr_in(fa), .dq_in(fdi), .cen_in(cen), .oen_in(oen),
      .wen_in(wen), .dq_out(mdq));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // controller status: fail counts only when ready
   function automatic logic [31:0] exp_st(input logic [7:0] f, input logic u);
      return {28'h0, u, 1'b0, f[7] & |(f & 8'h3A), 1'b0};
   endfunction
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask
   // one single transfer; waits on ready rather than assuming a latency
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
                      output logic [31:0] q);
      @(posedge clk_in);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk_in); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= v;
      do @(posedge clk_in); while (hready !== 1'b1);
      #1 q = hrdata_q;
   endtask
   task automatic op(input fsm_op_e o);
      logic [31:0] q;
      bus(1'b1, OFF_CTRL, {1'b1, 28'h0, o}, q);
      q = 32'h1;
      while (q[ST_BUSY_BIT] !== 1'b0) bus(1'b0, OFF_STATUS, 32'h0, q);
   endtask
   task automatic final_report;
      if (miscompares == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      // reset values, then an unmapped word that must stay zero
      bus(1'b1, 8'h40, 32'hFFFF_FFFF, r);
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, (i == 6) ? 8'h40 : 8'(4 * i), 32'h0, r);
         cmp(r, 32'h0);
      end
      // random status words, ready or busy, each followed by an array read
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         flash_u.sr = seed[7:0];
         flash_u.busy_cnt = {3'h0, seed[8]};
         s = {~seed[8], seed[6:0]};
         op(FSM_OP_STATUS);
         bus(1'b0, OFF_FSTAT, 32'h0, r);
         cmp(r, {24'h0, s & 8'hFE});
         bus(1'b0, OFF_STATUS, 32'h0, r);
         cmp(r, exp_st(s, up));
         bus(1'b1, OFF_ADDR, {20'h0, seed[27:16]}, r);
         op(FSM_OP_READ);
         bus(1'b0, OFF_RDATA, 32'h0, r);
         cmp(r, {16'h0, 4'hA, seed[27:16]});
      end
      // clear, reset and a raw clear write keep only the state bits
      bus(1'b1, OFF_WDATA, {24'h0, CMD_CLEAR}, r);
      for (int k = 0; k < 3; k++) begin
         flash_u.sr = 8'hFF;
         op((k == 0) ? FSM_OP_CLEAR : (k == 1) ? FSM_OP_RESET : FSM_OP_WRITE);
         op(FSM_OP_STATUS);
         bus(1'b0, OFF_FSTAT, 32'h0, r);
         cmp(r, 32'hC4);
      end
      // poll until ready; a second go meanwhile is refused and flagged
      flash_u.busy_cnt = 4'h3;
      bus(1'b1, OFF_CTRL, {1'b1, 28'h0, FSM_OP_POLL}, r);
      op(FSM_OP_CLEAR);
      bus(1'b0, OFF_FSTAT, 32'h0, r);
      cmp(r, 32'hC4);
      cmp({28'h0, flash_u.busy_cnt}, 32'h0);
      bus(1'b0, OFF_STATUS, 32'h0, r);
      cmp(r, 32'h4);
      // protection read of both states, then back in array mode
      for (int k = 0; k < 2; k++) begin
         flash_u.unprot = k[0];
         up = k[0];
         op(FSM_OP_PROT_RD);
         bus(1'b0, OFF_STATUS, 32'h0, r);
         cmp(r, exp_st(8'hC4, up));
         cmp({24'h0, flash_u.mode}, 32'h0);
      end
      // low byte kept off the status command value
      seed = xs(seed);
      d = {seed[15:8], 1'b1, seed[6:0]};
      bus(1'b1, OFF_WDATA, {16'h0, d}, r);
      op(FSM_OP_PW_PROG);
      for (int i = 0; i < 8; i++) cmp({16'h0, flash_u.pw[i]}, {16'h0, d});
      cmp({24'h0, flash_u.mode}, 32'h0);
      final_report();
   end
   // cuts a hang short; the tests need far fewer cycles
   initial begin
      #2_000_000;
      miscompares++;
      final_report();
   end
endmodule // fsm_host_test
`default_nettype wire
